// ==== src/mtpd_cfg.svh ====
`ifndef MTPD_CFG_SVH
`define MTPD_CFG_SVH

// register offsets
`define MTPD_ADDR_DETECT_CONFIG 8'h2b
`define MTPD_ADDR_INPUT_SELECT 8'h2d
`define MTPD_ADDR_BASELINE_RANGE 8'h2e

// pattern_detect_config fields
`define MTPD_CFG_ENABLE_BIT 7
`define MTPD_CFG_FRACTION_HI 3
`define MTPD_CFG_FRACTION_LO 2
`define MTPD_CFG_EXACT_BIT 1
`define MTPD_CFG_ALERT_BIT 0
`define MTPD_CFG_WRITE_MASK 8'h8f

// reset values
`define MTPD_DETECT_CONFIG_RESET 8'h00
`define MTPD_INPUT_SELECT_RESET 8'h3f
`define MTPD_BASELINE_RANGE_RESET 8'h00
`define MTPD_INPUT_SELECT_MASK 8'h3f

// geometry
`define MTPD_INPUTS 6
`define MTPD_DELTA_W 8
`define MTPD_THRESH_W 7

`endif

// ==== src/mtpd_pkg.sv ====
package mtpd_pkg;

   // pattern threshold as a fraction of the touch threshold
   typedef enum logic [1:0] {
      MTPD_FRAC_EIGHTH,
      MTPD_FRAC_QUARTER,
      MTPD_FRAC_THREE_EIGHTHS,
      MTPD_FRAC_FULL
   } mtpd_frac_e;

endpackage

// ==== src/mtpd_input_qualify.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mtpd_cfg.svh"

module mtpd_input_qualify (
   // setup
   input wire mtpd_pkg::mtpd_frac_e fraction,
   input wire logic useStandby,
   input wire logic enabled,
   // thresholds
   input wire logic [`MTPD_THRESH_W-1:0] inputThreshold,
   input wire logic [`MTPD_THRESH_W-1:0] standbyThreshold,
   // one sensing result
   input wire logic [`MTPD_DELTA_W-1:0] deltaCount,
   input wire logic noiseFlag,
   // verdict
   output logic qualifies
);

   logic [`MTPD_THRESH_W-1:0] baseThreshold;
   logic [`MTPD_THRESH_W-1:0] scaledThreshold;

   // standby inputs scale the shared standby threshold
   assign baseThreshold = useStandby ? standbyThreshold : inputThreshold;

   always_comb begin
      unique case (fraction)
         mtpd_pkg::MTPD_FRAC_EIGHTH: scaledThreshold = baseThreshold >> 3;
         mtpd_pkg::MTPD_FRAC_QUARTER: scaledThreshold = baseThreshold >> 2;
         mtpd_pkg::MTPD_FRAC_THREE_EIGHTHS: scaledThreshold = (baseThreshold >> 2) + (baseThreshold >> 3);
         mtpd_pkg::MTPD_FRAC_FULL: scaledThreshold = baseThreshold;
      endcase
   end

   // negative deltas never count as above threshold
   assign qualifies = enabled &&
      (noiseFlag || (!deltaCount[`MTPD_DELTA_W-1] && (deltaCount[`MTPD_DELTA_W-2:0] > scaledThreshold)));

endmodule // mtpd_input_qualify

`default_nettype wire

// ==== src/mtpd_pattern_detector.sv ====
// Operation
// - detector works only while config bit 7 is set; config resets to zero
// - pattern threshold is 12.5, 25, 37.5 or 100 percent of touch threshold
// - active inputs scale their own threshold, standby inputs the standby threshold
// - exact mode: every selected input above pattern threshold or noisy flags event
// - count mode: qualifying inputs at least number of selected bits flags event
// - condition judged on one sensing cycle only, nothing accumulated
// - pattern event blocks touch detection on all inputs and, with alert enable set, raises interrupt
// - blocking holds while condition persists and ends when it goes away
// - status flag held until host clears interrupt bit after condition ended
// - alert output asserted only if alert enable set; flag set regardless
// - six-bit input select register, bit n is input n+1, resets to all ones
// - read-only per-input baseline out-of-range bits, reset zero
// - any out-of-range bit sets the summary baseline flag
`timescale 1ns/1ns
`default_nettype none
`include "mtpd_cfg.svh"

module mtpd_pattern_detector (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   // sensing results, valid with sensingDone
   input wire logic sensingDone,
   input wire logic [`MTPD_INPUTS*`MTPD_DELTA_W-1:0] deltaCount,
   input wire logic [`MTPD_INPUTS-1:0] noiseFlag,
   input wire logic [`MTPD_INPUTS-1:0] baseOutOfRange,
   // sensing setup from the rest of the controller
   input wire logic standbyMode,
   input wire logic [`MTPD_INPUTS-1:0] activeEnable,
   input wire logic [`MTPD_INPUTS-1:0] standbyEnable,
   input wire logic [`MTPD_INPUTS*`MTPD_THRESH_W-1:0] inputThreshold,
   input wire logic [`MTPD_THRESH_W-1:0] standbyThreshold,
   // host wrote zero to the interrupt bit
   input wire logic intBitClear,
   // results
   output logic touchBlock,
   output logic patternEventFlag,
   output logic alert_b,
   output logic baselineRangeSummary
);

   logic [7:0] patternDetectConfig;
   logic [7:0] patternInputSelect;
   logic [7:0] baselineOutOfRange;

   logic patternDetectorEnable;
   mtpd_pkg::mtpd_frac_e patternThresholdFraction;
   logic exactSetSelect;
   logic patternAlertEnable;
   logic [`MTPD_INPUTS-1:0] selectVec;
   logic [`MTPD_INPUTS-1:0] qualifyVec;
   logic hitNow;
   logic eventNow;
   logic clearNow;

   function automatic logic [2:0] countOnes(input logic [`MTPD_INPUTS-1:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < `MTPD_INPUTS; i++) begin
         n = n + {2'h0, v[i]};
      end
      return n;
   endfunction

   assign patternDetectorEnable = patternDetectConfig[`MTPD_CFG_ENABLE_BIT];
   assign patternThresholdFraction =
      mtpd_pkg::mtpd_frac_e'(patternDetectConfig[`MTPD_CFG_FRACTION_HI:`MTPD_CFG_FRACTION_LO]);
   assign exactSetSelect = patternDetectConfig[`MTPD_CFG_EXACT_BIT];
   assign patternAlertEnable = patternDetectConfig[`MTPD_CFG_ALERT_BIT];
   assign selectVec = patternInputSelect[`MTPD_INPUTS-1:0];

   // register writes; reserved bits are dropped so they read back as zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         patternDetectConfig <= `MTPD_DETECT_CONFIG_RESET;
      end else if (regWrite && regAddr == `MTPD_ADDR_DETECT_CONFIG) begin
         patternDetectConfig <= regWdata & `MTPD_CFG_WRITE_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         patternInputSelect <= `MTPD_INPUT_SELECT_RESET;
      end else if (regWrite && regAddr == `MTPD_ADDR_INPUT_SELECT) begin
         patternInputSelect <= regWdata & `MTPD_INPUT_SELECT_MASK;
      end
   end

   // register reads, one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         unique case (regAddr)
            `MTPD_ADDR_DETECT_CONFIG: regRdata <= patternDetectConfig;
            `MTPD_ADDR_INPUT_SELECT: regRdata <= patternInputSelect;
            `MTPD_ADDR_BASELINE_RANGE: regRdata <= baselineOutOfRange;
            default: regRdata <= 8'h00;
         endcase
      end
   end

   // per-input qualification against the scaled threshold
   genvar g;
   generate
      for (g = 0; g < `MTPD_INPUTS; g++) begin : gQualify
         mtpd_input_qualify uQualify (
            .fraction(patternThresholdFraction),
            .useStandby(standbyMode && standbyEnable[g]),
            .enabled(standbyMode ? standbyEnable[g] : activeEnable[g]),
            .inputThreshold(inputThreshold[g*`MTPD_THRESH_W +: `MTPD_THRESH_W]),
            .standbyThreshold(standbyThreshold),
            .deltaCount(deltaCount[g*`MTPD_DELTA_W +: `MTPD_DELTA_W]),
            .noiseFlag(noiseFlag[g]),
            .qualifies(qualifyVec[g])
         );
      end
   endgenerate

   // an empty selection would match every cycle, so it never fires
   always_comb begin
      if (!patternDetectorEnable || selectVec == '0) begin
         hitNow = 1'b0;
      end else if (exactSetSelect) begin
         hitNow = (qualifyVec & selectVec) == selectVec;
      end else begin
         hitNow = countOnes(qualifyVec) >= countOnes(selectVec);
      end
   end

   // judged only on the current sensing result
   assign eventNow = sensingDone && hitNow;
   assign clearNow = intBitClear && !touchBlock && !eventNow;

   // blocking follows the condition of each sensing cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         touchBlock <= 1'b0;
      end else if (!patternDetectorEnable) begin
         touchBlock <= 1'b0;
      end else if (sensingDone) begin
         touchBlock <= hitNow;
      end
   end

   // a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         patternEventFlag <= 1'b0;
      end else if (eventNow) begin
         patternEventFlag <= 1'b1;
      end else if (clearNow) begin
         patternEventFlag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alert_b <= 1'b1;
      end else if (eventNow && patternAlertEnable) begin
         alert_b <= 1'b0;
      end else if (clearNow) begin
         alert_b <= 1'b1;
      end
   end

   // baseline range status captured with each sensing result
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         baselineOutOfRange <= `MTPD_BASELINE_RANGE_RESET;
      end else if (sensingDone) begin
         baselineOutOfRange <= {2'h0, baseOutOfRange};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         baselineRangeSummary <= 1'b0;
      end else if (sensingDone) begin
         baselineRangeSummary <= |baseOutOfRange;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   disabled_no_block_a: assert property (
      !patternDetectorEnable |=> !touchBlock)
      else $error("touch blocked while detector disabled");

   full_fraction_hit_a: assert property (
      sensingDone && patternDetectorEnable && exactSetSelect && !standbyMode && activeEnable[0]
      && selectVec == 6'h01 && !noiseFlag[0] && patternThresholdFraction == mtpd_pkg::MTPD_FRAC_FULL
      && !deltaCount[7] && deltaCount[6:0] <= inputThreshold[6:0]
      |=> !touchBlock)
      else $error("full fraction fired at or below the touch threshold");

   eighth_fraction_hit_a: assert property (
      sensingDone && patternDetectorEnable && exactSetSelect && !standbyMode && activeEnable[0]
      && selectVec == 6'h01 && patternThresholdFraction == mtpd_pkg::MTPD_FRAC_EIGHTH
      && !deltaCount[7] && deltaCount[6:0] > (inputThreshold[6:0] >> 3)
      |=> touchBlock && patternEventFlag)
      else $error("delta above one eighth threshold missed");

   standby_threshold_a: assert property (
      sensingDone && patternDetectorEnable && exactSetSelect && standbyMode && standbyEnable[0]
      && selectVec == 6'h01 && patternThresholdFraction == mtpd_pkg::MTPD_FRAC_FULL
      && !deltaCount[7] && deltaCount[6:0] > standbyThreshold
      |=> touchBlock)
      else $error("standby input not judged on standby threshold");

   exact_set_event_a: assert property (
      sensingDone && patternDetectorEnable && exactSetSelect && selectVec != 6'h00
      && (qualifyVec & selectVec) == selectVec
      |=> touchBlock && patternEventFlag)
      else $error("exact pattern match not flagged");

   count_mode_event_a: assert property (
      sensingDone && patternDetectorEnable && !exactSetSelect && selectVec != 6'h00
      && countOnes(qualifyVec) >= countOnes(selectVec)
      |=> touchBlock && patternEventFlag)
      else $error("minimum count reached but not flagged");

   single_cycle_judge_a: assert property (
      sensingDone && !hitNow |=> !touchBlock)
      else $error("block kept from an earlier sensing cycle");

   block_holds_a: assert property (
      touchBlock && !sensingDone && patternDetectorEnable |=> touchBlock)
      else $error("block dropped between sensing cycles");

   flag_held_a: assert property (
      patternEventFlag && (!intBitClear || touchBlock) |=> patternEventFlag)
      else $error("status flag lost without a valid clear");

   flag_clears_a: assert property (
      patternEventFlag && clearNow |=> !patternEventFlag && alert_b)
      else $error("valid clear did not drop flag and alert");

   alert_gated_a: assert property (
      $fell(alert_b) |-> $past(patternAlertEnable) && patternEventFlag)
      else $error("alert asserted without alert enable");

   flag_without_alert_a: assert property (
      eventNow && !patternAlertEnable && alert_b |=> patternEventFlag && alert_b)
      else $error("flag missing or alert raised while alert disabled");

   select_write_a: assert property (
      regWrite && regAddr == `MTPD_ADDR_INPUT_SELECT
      |=> patternInputSelect == ($past(regWdata) & `MTPD_INPUT_SELECT_MASK))
      else $error("input select write not stored as six bits");

   baseline_capture_a: assert property (
      sensingDone |=> baselineOutOfRange == {2'h0, $past(baseOutOfRange)})
      else $error("baseline range bits not captured");

   baseline_summary_a: assert property (
      baselineRangeSummary == (|baselineOutOfRange))
      else $error("summary baseline flag disagrees with per-input bits");

   // a single missing input must keep the block down
   exact_set_miss_a: assert property (
      sensingDone && patternDetectorEnable && exactSetSelect && (qualifyVec & selectVec) != selectVec
      |=> !touchBlock)
      else $error("exact pattern blocked with a selected input missing");

   count_mode_miss_a: assert property (
      sensingDone && patternDetectorEnable && !exactSetSelect
      && countOnes(qualifyVec) < countOnes(selectVec)
      |=> !touchBlock)
      else $error("block raised below the minimum count");

   disabled_no_flag_a: assert property (
      !patternDetectorEnable && !patternEventFlag |=> !patternEventFlag)
      else $error("status flag set while detector disabled");

   config_write_a: assert property (
      regWrite && regAddr == `MTPD_ADDR_DETECT_CONFIG
      |=> patternDetectConfig == ($past(regWdata) & `MTPD_CFG_WRITE_MASK))
      else $error("config write not stored");

   block_needs_sense_a: assert property (
      !touchBlock && !sensingDone |=> !touchBlock)
      else $error("block raised without a sensing result");

   alert_held_a: assert property (
      !alert_b && !clearNow |=> !alert_b)
      else $error("alert released without a valid clear");

   // host writes must never reach the status bits
   baseline_held_a: assert property (
      !sensingDone |=> $stable(baselineOutOfRange))
      else $error("baseline range bits changed without a sensing result");

   exact_hit_c: cover property (eventNow && exactSetSelect);
   count_hit_c: cover property (eventNow && !exactSetSelect);
   alert_low_c: cover property ($fell(alert_b));
   flag_cleared_c: cover property ($fell(patternEventFlag));
   standby_hit_c: cover property (eventNow && standbyMode);

endmodule // mtpd_pattern_detector

`default_nettype wire

// ==== verif/mtpd_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module mtpd_host_model (
   // register port
   input wire logic clk,
   input wire logic [7:0] regRdata,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWdata,
   // interrupt bit write
   output logic intBitClear
);
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
      intBitClear = 1'b0;
   end
   // released bus must not keep showing the last value
   task automatic idle();
      regAddr = ~regAddr;
      regWdata = ~regWdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
      idle();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      d = regRdata;
      idle();
   endtask
   task automatic clr();
      @(negedge clk);
      intBitClear = 1'b1;
      @(negedge clk);
      intBitClear = 1'b0;
   endtask
endmodule // mtpd_host_model
`default_nettype wire

// ==== verif/multi_touch_pattern_detector_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module multi_touch_pattern_detector_tb;
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] sel;
      logic [47:0] d;
      logic [5:0] n;
      logic s;
      logic hit;
   } mtpd_row_s;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic regWrite, regRead, intBitClear, sensingDone = 1'b0, standbyMode = 1'b0;
   logic [7:0] regAddr, regWdata, regRdata, rdv;
   logic [47:0] deltaCount = 48'h0;
   logic [5:0] noiseFlag = 6'h0, baseOutOfRange = 6'h0;
   logic [5:0] activeEnable = 6'h3f, standbyEnable = 6'h3f;
   logic [41:0] inputThreshold = {6{7'h40}};
   logic touchBlock, patternEventFlag, alert_b, baselineRangeSummary;
   int err_count = 0;
   int total_checks = 0;
   // fraction thresholds 8/16/24/64 active, 4/32 in standby
   mtpd_row_s rows [11] = '{
      '{8'h80, 8'h3f, 48'h090909090909, 6'h00, 1'b0, 1'b1},
      '{8'h81, 8'h3f, 48'h080808080808, 6'h00, 1'b0, 1'b0},
      '{8'h85, 8'h03, 48'h111100000000, 6'h00, 1'b0, 1'b1},
      '{8'h8b, 8'h03, 48'h191900000000, 6'h00, 1'b0, 1'b0},
      '{8'h8b, 8'h03, 48'h000000001919, 6'h00, 1'b0, 1'b1},
      '{8'h8f, 8'h01, 48'h000000000040, 6'h01, 1'b0, 1'b1},
      '{8'h0f, 8'h01, 48'h00000000007f, 6'h00, 1'b0, 1'b0},
      '{8'h81, 8'h01, 48'h000000000005, 6'h00, 1'b1, 1'b1},
      '{8'h82, 8'h01, 48'h000000000009, 6'h00, 1'b0, 1'b1},
      '{8'h8f, 8'h01, 48'h000000000040, 6'h00, 1'b0, 1'b0},
      '{8'h8e, 8'h01, 48'h000000000021, 6'h00, 1'b1, 1'b1}};
   logic [7:0] mt [4][3] = '{'{8'h2b, 8'hff, 8'h8f}, '{8'h2d, 8'hff, 8'h3f},
      '{8'h2e, 8'h55, 8'h00}, '{8'h10, 8'h55, 8'h00}};

   always #10 clk = ~clk;

   mtpd_host_model u_host (.clk(clk), .regRdata(regRdata), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .intBitClear(intBitClear));
   mtpd_pattern_detector u_dut (.clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .sensingDone(sensingDone),
      .deltaCount(deltaCount), .noiseFlag(noiseFlag), .baseOutOfRange(baseOutOfRange),
      .standbyMode(standbyMode), .activeEnable(activeEnable), .standbyEnable(standbyEnable),
      .inputThreshold(inputThreshold), .standbyThreshold(7'h20), .intBitClear(intBitClear),
      .touchBlock(touchBlock), .patternEventFlag(patternEventFlag), .alert_b(alert_b),
      .baselineRangeSummary(baselineRangeSummary));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic sense(input logic [47:0] d, input logic [5:0] n, input logic [5:0] b);
      @(negedge clk);
      deltaCount = d;
      noiseFlag = n;
      baseOutOfRange = b;
      sensingDone = 1'b1;
      @(negedge clk);
      sensingDone = 1'b0;
      deltaCount = ~d;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      chk(touchBlock, 1'b0);
      chk(patternEventFlag, 1'b0);
      chk(alert_b, 1'b1);
      chk(baselineRangeSummary, 1'b0);
      u_host.rd(8'h2b, rdv);
      chk(rdv, 8'h00);
      u_host.rd(8'h2d, rdv);
      chk(rdv, 8'h3f);
      u_host.rd(8'h2e, rdv);
      chk(rdv, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 11; i++) begin
         u_host.wr(8'h2b, rows[i].cfg);
         u_host.wr(8'h2d, rows[i].sel);
         standbyMode = rows[i].s;
         sense(rows[i].d, rows[i].n, 6'h00);
         chk(touchBlock, rows[i].hit);
         chk(patternEventFlag, rows[i].hit);
         chk(alert_b, !(rows[i].hit && rows[i].cfg[0]));
         sense(48'h0, 6'h00, 6'h00);
         chk(touchBlock, 1'b0);
         u_host.clr();
         chk(patternEventFlag, 1'b0);
         chk(alert_b, 1'b1);
         $display("row %0d done", i);
      end
      standbyMode = 1'b0;
      for (int i = 0; i < 4; i++) begin
         u_host.wr(mt[i][0], mt[i][1]);
         u_host.rd(mt[i][0], rdv);
         chk(rdv, mt[i][2]);
      end
      $display("register test done");
      u_host.wr(8'h2b, 8'h81);
      u_host.wr(8'h2d, 8'h30);
      sense(48'h090900000000, 6'h00, 6'h00);
      u_host.clr();
      chk(patternEventFlag, 1'b1);
      sense(48'h090900000000, 6'h00, 6'h00);
      chk(touchBlock, 1'b1);
      sense(48'h000900000000, 6'h00, 6'h00);
      chk(touchBlock, 1'b0);
      sense(48'h090000000000, 6'h00, 6'h00);
      chk(touchBlock, 1'b0);
      chk(patternEventFlag, 1'b1);
      chk(alert_b, 1'b0);
      u_host.clr();
      chk(patternEventFlag, 1'b0);
      $display("hold test done");
      sense(48'h0, 6'h00, 6'h04);
      u_host.rd(8'h2e, rdv);
      chk(rdv, 8'h04);
      chk(baselineRangeSummary, 1'b1);
      sense(48'h0, 6'h00, 6'h00);
      chk(baselineRangeSummary, 1'b0);
      $display("baseline test done");
      // input 2 alone gets a lower threshold: one eighth of 16 is 2
      inputThreshold[13:7] = 7'h10;
      u_host.wr(8'h2b, 8'h82);
      u_host.wr(8'h2d, 8'h02);
      sense(48'h000000000500, 6'h00, 6'h00);
      chk(touchBlock, 1'b1);
      activeEnable = 6'h3d;
      sense(48'h000000000500, 6'h00, 6'h00);
      chk(touchBlock, 1'b0);
      activeEnable = 6'h3f;
      standbyMode = 1'b1;
      standbyEnable = 6'h3d;
      sense(48'h000000000500, 6'h00, 6'h00);
      chk(touchBlock, 1'b0);
      standbyMode = 1'b0;
      standbyEnable = 6'h3f;
      inputThreshold[13:7] = 7'h40;
      u_host.clr();
      chk(patternEventFlag, 1'b0);
      $display("threshold test done");
      u_host.wr(8'h2b, 8'h81);
      sense(48'h090909090909, 6'h00, 6'h00);
      chk(alert_b, 1'b0);
      @(negedge clk);
      rst_b = 1'b0;
      @(negedge clk);
      rst_b = 1'b1;
      chk(touchBlock, 1'b0);
      chk(patternEventFlag, 1'b0);
      chk(alert_b, 1'b1);
      u_host.rd(8'h2b, rdv);
      chk(rdv, 8'h00);
      u_host.rd(8'h2d, rdv);
      chk(rdv, 8'h3f);
      $display("mid-run reset test done");
      wrap_up();
   end
endmodule // multi_touch_pattern_detector_tb
`default_nettype wire
